// *** bccd_pkg.sv ***
package bccd_pkg;

  // ----------------------------------------
  // Load sequence word indices (flash side)
  // ----------------------------------------
  localparam logic [3:0] WIDX_MODE    = 4'h0; // Partition mode word
  localparam logic [3:0] WIDX_SEQ1    = 4'h1; // Partition one boot sequence word
  localparam logic [3:0] WIDX_SEQ2    = 4'h2; // Partition two boot sequence word
  localparam logic [3:0] WIDX_PROT    = 4'h3; // Code protect word, active set
  localparam logic [3:0] WIDX_BOOT_SEGMENT_LIMIT   = 4'h4; // Boot segment limit word
  localparam logic [3:0] WIDX_SIGN    = 4'h5; // Signature reserved word
  localparam logic [3:0] WIDX_OSCSEL  = 4'h6; // Oscillator select word
  localparam logic [3:0] WIDX_OSCCFG  = 4'h7; // Oscillator config word
  localparam logic [3:0] WIDX_LAST    = 4'h7; // Last word of the load

  // ----------------------------------------
  // Register read offsets (own choice)
  // ----------------------------------------
  localparam logic [3:0] REG_MODE     = 4'h0;
  localparam logic [3:0] REG_SEQ      = 4'h1;
  localparam logic [3:0] REG_PROT     = 4'h2;
  localparam logic [3:0] REG_BOOT_SEGMENT_LIMIT    = 4'h3;
  localparam logic [3:0] REG_SIGN     = 4'h4;
  localparam logic [3:0] REG_OSCSEL   = 4'h5;
  localparam logic [3:0] REG_OSCCFG   = 4'h6;
  localparam logic [3:0] REG_STATUS   = 4'h7;
  localparam logic [3:0] REG_PINLOCK  = 4'h8;

  // ----------------------------------------
  // Implemented bit masks; others read as one
  // ----------------------------------------
  localparam logic [23:0] MASK_MODE   = 24'h000003;
  localparam logic [23:0] MASK_SEQ    = 24'hFFFFFF;
  localparam logic [23:0] MASK_PROT   = 24'h008FEF;
  localparam logic [23:0] MASK_BOOT_SEGMENT_LIMIT  = 24'h001FFF;
  localparam logic [23:0] MASK_SIGN   = 24'h008000;
  localparam logic [23:0] MASK_OSCSEL = 24'h0003FF;
  localparam logic [23:0] MASK_OSCCFG = 24'h0000FF;
  localparam logic [23:0] ERASED_WORD = 24'hFFFFFF;
  localparam logic [12:0] BOOT_SEGMENT_LIMIT_ALL1  = 13'h1FFF;

  // ----------------------------------------
  // Field encodings
  // ----------------------------------------
  localparam logic [1:0] PMODE_SINGLE = 2'h3;
  localparam logic [1:0] PMODE_DUAL   = 2'h2;
  localparam logic [1:0] PMODE_PDUAL  = 2'h1;
  localparam logic [3:0] MUL_NONE     = 4'hF;
  localparam logic [3:0] MUL_X8       = 4'hE;
  localparam logic [3:0] MUL_X6       = 4'hD;
  localparam logic [3:0] MUL_X4       = 4'hC;
  localparam logic [1:0] POSC_OFF     = 2'h3;
  localparam logic [1:0] POSC_EXT     = 2'h0;
  localparam logic [2:0] OSC_FRC      = 3'h0;

  // Protection level decode
  typedef enum logic [1:0] {
    BCCD_PROT_NONE = 2'b00,
    BCCD_PROT_STD  = 2'b01,
    BCCD_PROT_ENH  = 2'b10,
    BCCD_PROT_HIGH = 2'b11
  } bccd_prot_e;

  // Loader states
  typedef enum logic [1:0] {
    BCCD_LOAD = 2'b00,
    BCCD_PICK = 2'b01,
    BCCD_DONE = 2'b10
  } bccd_state_e;

  // Flash read request toward the storage
  typedef struct packed {
    logic        rd;
    logic [3:0]  idx;
    logic        part2;
  } bccd_flash_req_s;

  // Decoded configuration toward consumers
  typedef struct packed {
    logic        valid;
    logic [1:0]  part_mode;
    logic        dual;
    logic        part1_write_protect;
    logic        active_part2;
    logic        alt_vec_enable_avail;
    bccd_prot_e  cfg_prot;
    logic        cfg_write_protect;
    logic        boot_seg_exists;
    logic [12:0] boot_seg_first_gs_page;
    logic        two_speed_startup;
    logic [2:0]  startup_osc;
    logic [2:0]  target_osc;
    logic        mul_enable_avail;
    logic [3:0]  mul_factor;
    logic        usb_pll;
    logic [5:0]  usb_in_mhz;
    logic        clk_switch_en;
    logic        fail_safe_en;
    logic        pin_lock_one_way;
    logic        mul_src_primary;
    logic        secondary_oscillator_crystal;
    logic        clk_out_en;
    logic [1:0]  primary_osc_mode;
  } bccd_cfg_s;

endpackage

// *** bccd_osc_decode.sv ***
`timescale 1ns/1ps
module bccd_osc_decode
  import bccd_pkg::*;
(
  // Loaded words
  input  wire logic [23:0] osc_select_word,
  input  wire logic [23:0] osc_config_word,
  // Decoded fields
  output logic             two_speed,
  output logic [2:0]       startup_osc,
  output logic [2:0]       target_osc,
  output logic             mul_avail,
  output logic [3:0]       mul_factor,
  output logic             usb_pll,
  output logic [5:0]       usb_in_mhz,
  output logic             sw_en,
  output logic             fsm_en,
  output logic             one_way,
  output logic             src_primary,
  output logic             secondary_oscillator_xtal,
  output logic             clk_out,
  output logic [1:0]       posc_mode
);

  // ----------------------------------------
  // Pure decode of the oscillator words
  // ----------------------------------------
  always_comb begin
    two_speed   = osc_select_word[7];
    target_osc  = osc_select_word[2:0];
    // Fast RC first, then hardware switches when target is ready
    startup_osc = two_speed ? OSC_FRC : target_osc;
    mul_avail   = osc_select_word[6:3] != MUL_NONE;
    usb_pll     = 1'b0;
    usb_in_mhz  = 6'h00;
    case (osc_select_word[6:3])
      MUL_X8:  mul_factor = 4'h8;
      MUL_X6:  mul_factor = 4'h6;
      MUL_X4:  mul_factor = 4'h4;
      default: mul_factor = 4'h0;
    endcase
    case (osc_select_word[6:3])
      4'h7: usb_in_mhz = 6'h30;
      4'h6: usb_in_mhz = 6'h20;
      4'h5: usb_in_mhz = 6'h18;
      4'h4: usb_in_mhz = 6'h14;
      4'h3: usb_in_mhz = 6'h10;
      4'h2: usb_in_mhz = 6'h0C;
      4'h1: usb_in_mhz = 6'h08;
      4'h0: usb_in_mhz = 6'h04;
      default: usb_in_mhz = 6'h00;
    endcase
    usb_pll     = ~osc_select_word[6];
    // Switching disabled for 1x; monitor only for 00
    sw_en       = ~osc_config_word[7];
    fsm_en      = osc_config_word[7:6] == 2'b00;
    one_way     = osc_config_word[5];
    src_primary = osc_config_word[4];
    secondary_oscillator_xtal   = osc_config_word[3];
    posc_mode   = osc_config_word[1:0];
    // Clock out only when primary is off or fed externally
    clk_out     = osc_config_word[2] &&
                  (posc_mode == POSC_OFF || posc_mode == POSC_EXT);
  end

endmodule

// *** bccd_config_loader.sv ***
`timescale 1ns/1ps
// What this block does
// - Partition mode: 11 single, 10 dual, 01 protected
// - Sequence word: inverse 23:12, number 11:0
// - Dual modes: lower sequence number becomes active
// - Unimplemented configuration bits read back one
// - Bits program once; device treats read-only
// - Protection 111 none, 110 std, 10x, 0xx
// - Boot segment control one means no segment
// - Limit field is inverted first general page
// - Limit all ones gives zero boot segment
// - Two-speed start on fast RC, then switch
// - Multiplier 1111 none, 1110 8x, 1101 6x, 1100 4x
// - Lower codes pick USB PLL with input frequency
// - Three-bit initial oscillator select decode
// - Switch/monitor: 1x off, 01 switch, 00 both
// - One-way lock lets pin lock set once
// - Multiplier source: primary or fast RC
// - Secondary oscillator crystal or digital input
// - Clock output gated by primary mode
// - Primary mode: off, HS, XT, external
// - Reload on every reset; single mode skips the two sequence words
// - Active partition's words from the protect word on configure the device; the mode word is always read from partition one
module bccd_config_loader
  import bccd_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      nrst,
  // Flash configuration storage
  output bccd_pkg::bccd_flash_req_s      flash_req,
  input  wire logic [23:0]               flash_rdata,
  // Register port
  input  wire logic [3:0]                reg_addr,
  input  wire logic [23:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic [23:0]                    reg_rdata,
  // Unlock sequence qualifier for the pin lock
  input  wire logic                      pin_unlock,
  // Decoded configuration
  output bccd_pkg::bccd_cfg_s            cfg,
  output logic                           pin_mapping_lock
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    bccd_state_e     state;
    logic [3:0]      idx;        // Word being fetched
    logic            rd_wait;    // Data from the storage is due this cycle
    logic            pend;       // A read is in flight
    logic [23:0]     w_mode;
    logic [23:0]     w_seq1;
    logic [23:0]     w_seq2;
    logic [23:0]     w_prot;
    logic [23:0]     w_boot_segment_limit;
    logic [23:0]     w_sign;
    logic [23:0]     w_oscsel;
    logic [23:0]     w_osccfg;
    logic            active2;
    logic            lock;
    logic            lock_set_once;
    bccd_flash_req_s req;
    logic [23:0]     rdata;
    bccd_cfg_s       cfg;
  } bccd_loader_s;

  bccd_loader_s st;      // Registered state
  bccd_loader_s next_st; // Next state

  // Oscillator decode outputs
  logic             d_two_speed;
  logic [2:0]       d_startup;
  logic [2:0]       d_target;
  logic             d_mul_avail;
  logic [3:0]       d_mul;
  logic             d_usb;
  logic [5:0]       d_usb_in;
  logic             d_sw;
  logic             d_fsm;
  logic             d_one_way;
  logic             d_src;
  logic             d_secondary_oscillator;
  logic             d_clkout;
  logic [1:0]       d_posc;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Unimplemented positions are forced to one
  function automatic logic [23:0] rd_fill(input logic [23:0] w, input logic [23:0] m);
    rd_fill = w | ~m;
  endfunction

  // A sequence number whose complement field disagrees is treated as erased,
  // so a half-programmed word can never win the boot election.
  function automatic logic [11:0] seq_num(input logic [23:0] w);
    seq_num = (w[23:12] == ~w[11:0]) ? w[11:0] : 12'hFFF;
  endfunction

  function automatic bccd_prot_e prot_dec(input logic [2:0] l);
    if (l == 3'b111) begin
      prot_dec = BCCD_PROT_NONE;
    end else if (l == 3'b110) begin
      prot_dec = BCCD_PROT_STD;
    end else if (l[2]) begin
      prot_dec = BCCD_PROT_ENH;
    end else begin
      prot_dec = BCCD_PROT_HIGH;
    end
  endfunction

  // ----------------------------------------
  // Oscillator decode
  // ----------------------------------------
  bccd_osc_decode u_osc (
    .osc_select_word (st.w_oscsel),
    .osc_config_word (st.w_osccfg),
    .two_speed       (d_two_speed),
    .startup_osc     (d_startup),
    .target_osc      (d_target),
    .mul_avail       (d_mul_avail),
    .mul_factor      (d_mul),
    .usb_pll         (d_usb),
    .usb_in_mhz      (d_usb_in),
    .sw_en           (d_sw),
    .fsm_en          (d_fsm),
    .one_way         (d_one_way),
    .src_primary     (d_src),
    .secondary_oscillator_xtal       (d_secondary_oscillator),
    .clk_out         (d_clkout),
    .posc_mode       (d_posc)
  );

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic dual_v;
    logic [3:0] nidx;
    dual_v  = 1'b0;
    nidx    = 4'h0;
    next_st = st;
    next_st.req.rd = 1'b0;
    next_st.rd_wait = st.req.rd;
    dual_v = st.w_mode[1:0] == PMODE_DUAL || st.w_mode[1:0] == PMODE_PDUAL;

    case (st.state)
      // Fetch one word per three cycles: request, wait, then capture
      BCCD_LOAD: begin
        if (st.rd_wait) begin
          case (st.idx)
            WIDX_MODE:   next_st.w_mode   = flash_rdata;
            WIDX_SEQ1:   next_st.w_seq1   = flash_rdata;
            WIDX_SEQ2:   next_st.w_seq2   = flash_rdata;
            WIDX_PROT:   next_st.w_prot   = flash_rdata;
            WIDX_BOOT_SEGMENT_LIMIT:  next_st.w_boot_segment_limit  = flash_rdata;
            WIDX_SIGN:   next_st.w_sign   = flash_rdata;
            WIDX_OSCSEL: next_st.w_oscsel = flash_rdata;
            WIDX_OSCCFG: next_st.w_osccfg = flash_rdata;
            default:     next_st.w_sign   = st.w_sign;
          endcase
          next_st.pend = 1'b0;
          if (st.idx == WIDX_SEQ2) begin
            // Election happens before the user words are read
            next_st.state = BCCD_PICK;
          end else if (st.idx == WIDX_LAST) begin
            next_st.state = BCCD_DONE;
          end else begin
            nidx = st.idx + 4'h1;
            // Single mode has no sequence words to read
            if (st.idx == WIDX_MODE && !(flash_rdata[1:0] == PMODE_DUAL ||
                flash_rdata[1:0] == PMODE_PDUAL)) begin
              nidx = WIDX_PROT;
            end
            next_st.idx = nidx;
          end
        end else if (!st.pend) begin
          next_st.req.rd    = 1'b1;
          next_st.req.idx   = st.idx;
          next_st.req.part2 = (st.idx == WIDX_SEQ2) ? 1'b1 : st.active2;
          next_st.pend      = 1'b1;
        end
      end
      // Lower number wins; a tie keeps partition one
      BCCD_PICK: begin
        next_st.active2 = dual_v &&
                          (seq_num(st.w_seq2) < seq_num(st.w_seq1));
        next_st.idx     = WIDX_PROT;
        next_st.state   = BCCD_LOAD;
      end
      // Words are frozen until the next reset
      BCCD_DONE: begin
        next_st.state = BCCD_DONE;
      end
      default: begin
        next_st.state = BCCD_LOAD;
      end
    endcase

    // Decoded outputs follow the loaded words
    next_st.cfg.valid                  = st.state == BCCD_DONE;
    next_st.cfg.part_mode              = st.w_mode[1:0];
    next_st.cfg.dual                   = dual_v;
    next_st.cfg.part1_write_protect    = st.w_mode[1:0] == PMODE_PDUAL &&
                                         st.active2;
    next_st.cfg.active_part2           = st.active2;
    next_st.cfg.alt_vec_enable_avail   = ~st.w_prot[15];
    next_st.cfg.cfg_prot               = prot_dec(st.w_prot[11:9]);
    next_st.cfg.cfg_write_protect      = ~st.w_prot[8];
    next_st.cfg.boot_seg_exists        = ~st.w_prot[3] &&
                                         st.w_boot_segment_limit[12:0] != BOOT_SEGMENT_LIMIT_ALL1;
    next_st.cfg.boot_seg_first_gs_page = ~st.w_boot_segment_limit[12:0];
    next_st.cfg.two_speed_startup      = d_two_speed;
    next_st.cfg.startup_osc            = d_startup;
    next_st.cfg.target_osc             = d_target;
    next_st.cfg.mul_enable_avail       = d_mul_avail;
    next_st.cfg.mul_factor             = d_mul;
    next_st.cfg.usb_pll                = d_usb;
    next_st.cfg.usb_in_mhz             = d_usb_in;
    next_st.cfg.clk_switch_en          = d_sw;
    next_st.cfg.fail_safe_en           = d_fsm;
    next_st.cfg.pin_lock_one_way       = d_one_way;
    next_st.cfg.mul_src_primary        = d_src;
    next_st.cfg.secondary_oscillator_crystal           = d_secondary_oscillator;
    next_st.cfg.clk_out_en             = d_clkout;
    next_st.cfg.primary_osc_mode       = d_posc;

    // Pin lock: writes need the unlock qualifier
    if (reg_wr && reg_addr == REG_PINLOCK && pin_unlock && st.state == BCCD_DONE) begin
      if (reg_wdata[0] && !st.lock_set_once) begin
        next_st.lock = 1'b1;
        next_st.lock_set_once = d_one_way;
      end else if (!reg_wdata[0] && !d_one_way) begin
        next_st.lock = 1'b0;
      end
    end

    // Read data the cycle after the strobe; configuration writes are dropped
    next_st.rdata = 24'h000000;
    if (reg_rd) begin
      case (reg_addr)
        REG_MODE:    next_st.rdata = rd_fill(st.w_mode, MASK_MODE);
        REG_SEQ:     next_st.rdata = st.active2 ? st.w_seq2 : st.w_seq1;
        REG_PROT:    next_st.rdata = rd_fill(st.w_prot, MASK_PROT);
        REG_BOOT_SEGMENT_LIMIT:   next_st.rdata = rd_fill(st.w_boot_segment_limit, MASK_BOOT_SEGMENT_LIMIT);
        REG_SIGN:    next_st.rdata = rd_fill(st.w_sign, MASK_SIGN);
        REG_OSCSEL:  next_st.rdata = rd_fill(st.w_oscsel, MASK_OSCSEL);
        REG_OSCCFG:  next_st.rdata = rd_fill(st.w_osccfg, MASK_OSCCFG);
        REG_STATUS:  next_st.rdata = {20'h00000, st.active2, dual_v,
                                      st.state == BCCD_DONE, st.pend};
        REG_PINLOCK: next_st.rdata = {22'h000000, st.lock_set_once, st.lock};
        default:     next_st.rdata = 24'h000000;
      endcase
    end
  end

  // ----------------------------------------
  // State register; reset restarts the load
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st          <= '0;
      st.state    <= BCCD_LOAD;
      // Erased words until loaded, so nothing is trusted early
      st.w_mode   <= ERASED_WORD;
      st.w_seq1   <= ERASED_WORD;
      st.w_seq2   <= ERASED_WORD;
      st.w_prot   <= ERASED_WORD;
      st.w_boot_segment_limit  <= ERASED_WORD;
      st.w_sign   <= ERASED_WORD;
      st.w_oscsel <= ERASED_WORD;
      st.w_osccfg <= ERASED_WORD;
    end else begin
      st <= next_st;
    end
  end

  assign flash_req        = st.req;
  assign reg_rdata        = st.rdata;
  assign cfg              = st.cfg;
  assign pin_mapping_lock = st.lock;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_unimpl_ones;
    @(posedge clk) disable iff (!nrst)
      reg_rd && reg_addr == REG_MODE |=> reg_rdata[23:2] == 22'h3FFFFF;
  endproperty
  a_unimpl_ones: assert property (p_unimpl_ones) else $error("unimplemented bits not one");

  property p_tie_part1;
    @(posedge clk) disable iff (!nrst)
      st.state == BCCD_PICK && seq_num(st.w_seq1) == seq_num(st.w_seq2) |=> !st.active2;
  endproperty
  a_tie_part1: assert property (p_tie_part1) else $error("tie picked partition two");

  property p_lower_wins;
    @(posedge clk) disable iff (!nrst)
      st.state == BCCD_PICK && cfg.dual && seq_num(st.w_seq2) < seq_num(st.w_seq1)
      |=> st.active2;
  endproperty
  a_lower_wins: assert property (p_lower_wins) else $error("lower sequence not active");

  property p_frozen;
    @(posedge clk) disable iff (!nrst)
      st.state == BCCD_DONE |=> $stable(st.w_prot) && $stable(st.w_osccfg);
  endproperty
  a_frozen: assert property (p_frozen) else $error("config changed after load");

  property p_bseg;
    @(posedge clk) disable iff (!nrst)
      st.w_prot[3] |=> !cfg.boot_seg_exists;
  endproperty
  a_bseg: assert property (p_bseg) else $error("boot segment while disabled");

  property p_boot_segment_limit_ones;
    @(posedge clk) disable iff (!nrst)
      st.w_boot_segment_limit[12:0] == BOOT_SEGMENT_LIMIT_ALL1 |=> !cfg.boot_seg_exists;
  endproperty
  a_boot_segment_limit_ones: assert property (p_boot_segment_limit_ones) else $error("erased limit gave segment");

  property p_prot_high;
    @(posedge clk) disable iff (!nrst)
      !st.w_prot[11] |=> cfg.cfg_prot == BCCD_PROT_HIGH;
  endproperty
  a_prot_high: assert property (p_prot_high) else $error("protection decode wrong");

  property p_lock_once;
    @(posedge clk) disable iff (!nrst)
      st.lock_set_once && st.lock |=> st.lock;
  endproperty
  a_lock_once: assert property (p_lock_once) else $error("one-way lock cleared");

  property p_avt;
    @(posedge clk) disable iff (!nrst)
      st.w_prot[15] |=> !cfg.alt_vec_enable_avail;
  endproperty
  a_avt: assert property (p_avt) else $error("vector enable available while disabled");

  // Reset puts the loader back at the first word with nothing decoded
  sequence s_in_reset;
    !nrst;
  endsequence
  sequence s_load_start;
    st.state == BCCD_LOAD && st.idx == WIDX_MODE && !st.pend && !cfg.valid;
  endsequence
  property p_reload;
    @(posedge clk) s_in_reset |=> s_load_start;
  endproperty
  a_reload: assert property (p_reload) else $error("reset did not restart load");

endmodule

// *** bccd_flash_model.sv ***
`timescale 1ns/1ps
module bccd_flash_model
  import bccd_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Read request and answer
  input  wire bccd_flash_req_s  req,
  output logic [23:0]           rdata,
  output logic [3:0]            n_reqs,
  // Stored words of each partition
  input  wire logic [7:0][23:0] p1,
  input  wire logic [7:0][23:0] p2
);
  // ----------------------------------------
  // Storage answer
  // ----------------------------------------
  // Data stand only in the cycle after a request; elsewhere the bus flips so
  // a late capture in the loader shows up as a wrong word
  always_ff @(posedge clk) begin
    if (!nrst) begin
      n_reqs <= 4'h0;
      rdata  <= 24'h5A5A5A;
    end else if (req.rd) begin
      n_reqs <= n_reqs + 4'h1;
      rdata  <= req.part2 ? p2[req.idx[2:0]] : p1[req.idx[2:0]];
    end else begin
      rdata  <= ~rdata;
    end
  end
endmodule

// *** test_boot_and_clock_config_decode.sv ***
`timescale 1ns/1ps
module test_boot_and_clock_config_decode;
  import bccd_pkg::*;
  // ----------------------------------------
  // Signals and tables
  // ----------------------------------------
  logic              clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, pin_unlock = 0, lock;
  logic [3:0]        reg_addr = 4'h0, n_reqs, v, k;
  logic [23:0]       reg_wdata = 24'h0, fl_rdata, reg_rdata, d;
  logic [7:0][23:0]  p1, p2;
  bccd_flash_req_s   flash_req;
  bccd_cfg_s         cfg;
  int                failures = 0, n_tests = 0, c;
  // Multiplier codes swept and the USB input frequency each implies
  localparam logic [3:0]  PLL_T [10] = '{4'hF, 4'hE, 4'hD, 4'hC, 4'h7, 4'h6, 4'h5, 4'h4,
                                         4'h3, 4'h2};
  localparam logic [5:0]  MHZ_T [10] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h30, 6'h20, 6'h18,
                                         6'h14, 6'h10, 6'h0C};
  localparam logic [23:0] MSK [5] = '{MASK_PROT, MASK_BOOT_SEGMENT_LIMIT, MASK_SIGN, MASK_OSCSEL, MASK_OSCCFG};
  // Sequence words; the last one has a broken complement on purpose
  localparam logic [23:0] S1 [4] = '{24'hFFA005, 24'hFF8007, 24'hFF6009, 24'hFF6009};
  localparam logic [23:0] S2 [4] = '{24'hFFC003, 24'hFF8007, 24'hFFE001, 24'h000001};
  localparam logic [23:0] MD [4] = '{24'hFFFFFE, 24'hFFFFFE, 24'hFFFFFD, 24'hFFFFFD};
  localparam logic        A2 [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  always #20 clk = ~clk;

  bccd_config_loader dut (.clk(clk), .nrst(nrst), .flash_req(flash_req), .flash_rdata(fl_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_unlock(pin_unlock), .cfg(cfg), .pin_mapping_lock(lock));
  bccd_flash_model flash (.clk(clk), .nrst(nrst), .req(flash_req), .rdata(fl_rdata),
    .n_reqs(n_reqs), .p1(p1), .p2(p2));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  `define CHK(a, e) chk(a, e)
  task automatic chk(input logic [23:0] a, input logic [23:0] e);
    n_tests++;
    if (a !== e) begin
      failures++;
      $display("unexpected at %0t got %h expected %h", $time, a, e);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Read: strobe for one cycle, data taken in the following cycle only
  task automatic rd(input logic [3:0] a, output logic [23:0] q);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [23:0] q);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= q;
    @(posedge clk);
    reg_wr    <= 1'b0;
    #1;
  endtask
  // Reset for twelve cycles, then wait for the load under a bound
  task automatic boot;
    int n;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    // Look a little after each edge so the flag is settled when read
    for (n = 0; n < 200 && cfg.valid !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (cfg.valid !== 1'b1) begin
      failures++;
      wrap_up();
    end
    #1;
  endtask
  task automatic erase;
    p1 = {8{24'hFFFFFF}};
    p1[5] = 24'hFF7FFF;
    p2 = p1;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    erase();
    // Field decode sweep in single partition mode, one reload per step
    for (v = 0; v < 10; v++) begin
      erase();
      p1[3] = 24'hFF70F7 | {8'h0, v[0], 3'h0, v[2:0], v[1], 4'h0, v[2], 3'h0};
      p1[4] = 24'hFFFFFF << v;
      p1[6] = {14'h3FFF, 2'b00, v[0], PLL_T[v], v[2:0]};
      p1[7] = {16'hFFFF, v[1:0], v[2], v[0], v[1], v[2], v[1:0]};
      boot();
      `CHK(n_reqs, 6);
      `CHK(cfg.part_mode, PMODE_SINGLE);
      `CHK(cfg.dual, 0);
      `CHK(cfg.alt_vec_enable_avail, !v[0]);
      `CHK(cfg.cfg_prot, v[2:0] == 7 ? BCCD_PROT_NONE : v[2:0] == 6 ? BCCD_PROT_STD :
           v[2] ? BCCD_PROT_ENH : BCCD_PROT_HIGH);
      `CHK(cfg.cfg_write_protect, !v[1]);
      `CHK(cfg.boot_seg_exists, !v[2] && v != 4'h0);
      `CHK(cfg.boot_seg_first_gs_page, {11'h000, ~p1[4][12:0]});
      `CHK(cfg.two_speed_startup, v[0]);
      `CHK(cfg.startup_osc, v[0] ? OSC_FRC : v[2:0]);
      `CHK(cfg.target_osc, v[2:0]);
      `CHK(cfg.mul_enable_avail, PLL_T[v] != MUL_NONE);
      `CHK(cfg.mul_factor, v == 1 ? 8 : v == 2 ? 6 : v == 3 ? 4 : 0);
      `CHK(cfg.usb_pll, v > 3);
      `CHK(cfg.usb_in_mhz, MHZ_T[v]);
      `CHK(cfg.clk_switch_en, !v[1]);
      `CHK(cfg.fail_safe_en, v[1:0] == 0);
      `CHK(cfg.pin_lock_one_way, v[2]);
      `CHK(cfg.mul_src_primary, v[0]);
      `CHK(cfg.secondary_oscillator_crystal, v[1]);
      `CHK(cfg.clk_out_en, v[2] && (v[1:0] == POSC_OFF || v[1:0] == POSC_EXT));
      `CHK(cfg.primary_osc_mode, v[1:0]);
      // Pin lock: ignored without unlock, one-way keeps it set
      @(posedge clk) pin_unlock <= 1'b0;
      wr(REG_PINLOCK, 24'h1);
      `CHK(lock, 0);
      @(posedge clk) pin_unlock <= 1'b1;
      wr(REG_PINLOCK, 24'h1);
      `CHK(lock, 1);
      wr(REG_PINLOCK, 24'h0);
      `CHK(lock, v[2]);
      // Loaded words cannot be overwritten; unimplemented bits read one
      wr(REG_PROT, 24'h0);
      rd(REG_MODE, d);
      `CHK(d, p1[0] | ~MASK_MODE);
      for (k = 2; k < 7; k++) begin
        rd(k, d);
        `CHK(d, p1[k + 1] | ~MSK[k - 2]);
      end
    end
    rd(4'hF, d);
    `CHK(d, 0);
    // Dual modes: election by lower sequence number, tie and broken word
    for (c = 0; c < 4; c++) begin
      erase();
      p2[3] = 24'hFFFEFF;
      p1[0] = MD[c];
      p2[0] = MD[c];
      p1[1] = S1[c];
      p2[2] = S2[c];
      boot();
      `CHK(n_reqs, 8);
      `CHK(cfg.dual, 1);
      `CHK(cfg.part_mode, MD[c][1:0]);
      `CHK(cfg.active_part2, A2[c]);
      `CHK(cfg.part1_write_protect, MD[c][0] & A2[c]);
      `CHK(cfg.cfg_write_protect, A2[c]);
      rd(REG_SEQ, d);
      `CHK(d, A2[c] ? S2[c] : S1[c]);
      rd(REG_STATUS, d);
      `CHK(d, {20'h00000, A2[c], 3'b110});
      rd(REG_PROT, d);
      `CHK(d, (A2[c] ? 24'hFFFEFF : 24'hFFFFFF) | ~MASK_PROT);
    end
    wrap_up();
  end
endmodule
